// ===== hdl/prx_capture.sv
`timescale 1ns/1ns
`default_nettype none
`include "prx_defines.svh"

module prx_capture (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register port.
  input  wire prx_pkg::prx_bus_req_t bus_req,
  output var  prx_pkg::prx_bus_rsp_t bus_rsp,
  // Microphone link.
  input  wire logic                  mic_clk,
  input  wire logic [1:0]            mic_data,
  // Requests out.
  output var  logic                  dma_rx_req,
  output var  logic                  irq
);
  import prx_pkg::*;

  prx_state_t  st;
  prx_state_t  nxt;
  logic        setup;
  logic        access;
  logic        rd_setup;
  logic        wr;
  logic        mapped;
  logic        l_rise;
  logic        l_fall;
  logic        dec_last;
  logic [3:0][15:0] hy;
  logic [3:0]  hv_all;
  logic        hv;
  logic        in_vld;
  logic        in_ready;
  logic [31:0] in_word;
  logic        ovf_set;
  logic        ovf_clr;
  logic        b_out;
  logic        push;
  logic        pop;
  logic [7:0]  level;
  logic        thr;
  logic [1:0]  status;
  logic [1:0]  bcnt;
  logic [31:0] head_word;

  function automatic logic [15:0] pcm_of(input logic [6:0] ones);
    logic [6:0] s;
    logic [6:0] v;
    s = (ones == `PRX_ONES_MAX) ? (`PRX_ONES_MAX - 7'h01) : ones;
    v = s - `PRX_DEC_MID;
    pcm_of = {v[5:0], 10'h000};
  endfunction : pcm_of

  // ==========================================================================
  // Per-channel filters, path-major, left before right.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hpf
      prx_hpf u_hpf (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .in_vld  (st.raw_vld),
        .en      (g % 2 == 1 ? st.hpf_ctrl[`PRX_HPF_RIGHT_BIT]
                             : st.hpf_ctrl[`PRX_HPF_LEFT_BIT]),
        .cutoff  (prx_cutoff_t'(st.hpf_ctrl[`PRX_CUTOFF_MSB:0])),
        .x       (st.raw[g]),
        .y       (hy[g]),
        .y_vld   (hv_all[g])
      );
    end
  endgenerate
  assign hv = hv_all[0];

  // ==========================================================================
  // Combinational decode shared by the next-state logic and outputs.
  always_comb begin
    setup    = bus_req.sel & ~bus_req.enable;
    access   = bus_req.sel & bus_req.enable;
    rd_setup = setup & ~bus_req.write;
    wr       = access & bus_req.write;
    case (bus_req.addr)
      `PRX_OFS_HPF, `PRX_OFS_FIFO_CTRL, `PRX_OFS_DMA_CTRL,
      `PRX_OFS_INT_EN, `PRX_OFS_INT_CLR, `PRX_OFS_INT_ST,
      `PRX_OFS_RXDATA, `PRX_OFS_P0R, `PRX_OFS_P0L,
      `PRX_OFS_P1R: mapped = 1'b1;
      default:      mapped = 1'b0;
    endcase
    l_rise   = st.lclk_sync[1] & ~st.lclk_sync[2];
    l_fall   = ~st.lclk_sync[1] & st.lclk_sync[2];
    dec_last = l_fall && (st.bit_cnt == `PRX_DEC_LAST);
    level    = {1'b0, st.count};
    thr      = level >= ({1'b0, st.rft} + 8'h01);
    status   = {st.ovf, thr};
    in_vld   = st.pend != 2'b00;
    in_ready = st.buf_cnt != 2'b10;
    in_word  = st.pend[0] ? {st.smp[1], st.smp[0]}
                          : {st.smp[3], st.smp[2]};
    ovf_set  = in_vld & ~in_ready;
    ovf_clr  = wr && (bus_req.addr == `PRX_OFS_INT_CLR)
               && bus_req.wdata[`PRX_INT_OVF_BIT];
    b_out    = (st.buf_cnt != 2'b00) && (st.count != `PRX_FIFO_DEPTH);
    push     = b_out;
    pop      = rd_setup && (bus_req.addr == `PRX_OFS_RXDATA)
               && (st.count != 7'h00);
    head_word = st.mem[st.rptr];
  end

  // ==========================================================================
  // Next state.
  always_comb begin
    nxt         = st;
    nxt.raw_vld = 1'b0;
    bcnt        = st.buf_cnt;
    // Link clock and data pass two flops before any use.
    nxt.lclk_sync = {st.lclk_sync[1:0], mic_clk};
    nxt.d_s1      = mic_data;
    nxt.d_s2      = st.d_s1;
    // Left bits are taken on the rising edge, right bits on the falling.
    if (l_rise) begin
      for (int p = 0; p < 2; p++) begin
        nxt.ones_l[p] = st.ones_l[p] + {6'h00, st.d_s2[p]};
      end
    end
    if (l_fall) begin
      nxt.bit_cnt = st.bit_cnt + 6'h01;
      for (int p = 0; p < 2; p++) begin
        nxt.ones_r[p] = st.ones_r[p] + {6'h00, st.d_s2[p]};
      end
    end
    if (dec_last) begin
      nxt.raw_vld = 1'b1;
      for (int p = 0; p < 2; p++) begin
        nxt.raw[2 * p]     = pcm_of(st.ones_l[p]);
        nxt.raw[2 * p + 1] = pcm_of(st.ones_r[p] + {6'h00, st.d_s2[p]});
        nxt.ones_l[p]      = 7'h00;
        nxt.ones_r[p]      = 7'h00;
      end
    end
    // A new frame overwrites any word still pending; frames are far apart.
    if (hv) begin
      nxt.smp  = hy;
      nxt.pend = 2'b11;
    end else if (in_vld) begin
      // Offered word is either taken or dropped as overflow.
      if (st.pend[0]) begin
        nxt.pend[0] = 1'b0;
      end else begin
        nxt.pend[1] = 1'b0;
      end
    end
    // Two-entry buffer in front of the queue.
    if (b_out) begin
      nxt.bufm[0] = st.bufm[1];
      bcnt        = bcnt - 2'b01;
    end
    if (in_vld && in_ready) begin
      nxt.bufm[bcnt[0]] = in_word;
      bcnt              = bcnt + 2'b01;
    end
    nxt.buf_cnt = bcnt;
    // Queue.
    if (push) begin
      nxt.mem[st.wptr] = st.bufm[0];
      nxt.wptr         = st.wptr + 6'h01;
    end
    if (pop) begin
      nxt.rptr = st.rptr + 6'h01;
    end
    nxt.count = st.count + {6'h00, push} - {6'h00, pop};
    // Overflow is sticky; a set in the clearing cycle wins.
    nxt.ovf = (st.ovf & ~ovf_clr) | ovf_set;
    // Register writes take effect in the access phase.
    if (wr) begin
      case (bus_req.addr)
        `PRX_OFS_HPF: begin
          nxt.hpf_ctrl = bus_req.wdata[`PRX_HPF_LEFT_BIT:0];
        end
        `PRX_OFS_FIFO_CTRL: begin
          nxt.rft = bus_req.wdata[`PRX_RFT_MSB:`PRX_RFT_LSB];
        end
        `PRX_OFS_DMA_CTRL: begin
          nxt.dma_en = bus_req.wdata[`PRX_DMA_EN_BIT];
          nxt.rdl    = bus_req.wdata[`PRX_RDL_MSB:0];
        end
        `PRX_OFS_INT_EN: begin
          nxt.int_en = bus_req.wdata[`PRX_INT_OVF_BIT:0];
        end
        default: begin
        end
      endcase
    end
    // Read data is captured in the setup phase, so a pop happens once.
    if (rd_setup) begin
      case (bus_req.addr)
        `PRX_OFS_HPF:       nxt.rdata = {28'h0000000, st.hpf_ctrl};
        `PRX_OFS_FIFO_CTRL: nxt.rdata = {17'h00000, st.rft, level};
        `PRX_OFS_DMA_CTRL:  nxt.rdata = {23'h000000, st.dma_en, 1'b0,
                                         st.rdl};
        `PRX_OFS_INT_EN:    nxt.rdata = {30'h00000000, st.int_en};
        `PRX_OFS_INT_ST:    nxt.rdata = {30'h00000000, status};
        `PRX_OFS_RXDATA:    nxt.rdata = pop ? head_word : 32'h00000000;
        `PRX_OFS_P0R:       nxt.rdata = {{16{st.smp[1][15]}}, st.smp[1]};
        `PRX_OFS_P0L:       nxt.rdata = {{16{st.smp[0][15]}}, st.smp[0]};
        `PRX_OFS_P1R:       nxt.rdata = {{16{st.smp[3][15]}}, st.smp[3]};
        default:            nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st     <= '0;
      st.rdl <= `PRX_RDL_RESET;
    end else begin
      st <= nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  assign bus_rsp.ready  = access;
  assign bus_rsp.slverr = access & ~mapped;
  assign bus_rsp.rdata  = st.rdata;
  assign dma_rx_req = st.dma_en
                      && (level >= ({1'b0, st.rdl} + 8'h01));
  assign irq = |(status & st.int_en);

  // ==========================================================================
  // Checks.
  a_dma_gate_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !st.dma_en |-> !dma_rx_req)
    else $error("DMA request raised while disabled.");

  a_dma_watermark: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    st.dma_en |-> dma_rx_req == (st.count > st.rdl))
    else $error("DMA request does not match the watermark.");

  a_rdl_reset: assert property (
    @(posedge clk_sys)
    !rst_n |=> st.rdl == `PRX_RDL_RESET && !st.dma_en)
    else $error("Watermark reset value wrong.");

  a_thr_irq: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    st.int_en == 2'b01 |-> irq == (st.count > st.rft))
    else $error("Threshold interrupt disagrees with level.");

  a_level_field: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    push && !pop |=> st.count == $past(st.count) + 7'h01)
    else $error("Level did not count a stored word.");

  a_ovf_irq_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    st.int_en == 2'b10 |-> irq == st.ovf)
    else $error("Overflow interrupt gating wrong.");

  a_irq_masked: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    st.int_en == 2'b00 |-> !irq)
    else $error("Interrupt raised while masked.");

  a_ovf_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ovf_clr && !ovf_set |=> !st.ovf)
    else $error("Overflow not cleared.");

  a_ovf_sticky: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ovf_set |=> (st.ovf && ovf_clr) or (st.ovf ##1 st.ovf))
    else $error("Overflow not set or not held.");

  a_pop_oldest: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pop |=> bus_rsp.rdata == $past(head_word)
            && st.rptr == $past(st.rptr) + 6'h01)
    else $error("Queue read did not return and drop the head.");

  a_sample_regs: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    hv |=> st.smp[1] == $past(hy[1]) && st.smp[0] == $past(hy[0]))
    else $error("Sample registers not updated.");

endmodule : prx_capture
`default_nettype wire

// ===== hdl/prx_defines.svh
`ifndef PRX_DEFINES_SVH
`define PRX_DEFINES_SVH

// ==========================================================================
// Register offsets.
`define PRX_OFS_HPF        8'h10
`define PRX_OFS_FIFO_CTRL  8'h14
`define PRX_OFS_DMA_CTRL   8'h18
`define PRX_OFS_INT_EN     8'h1c
`define PRX_OFS_INT_CLR    8'h20
`define PRX_OFS_INT_ST     8'h24
`define PRX_OFS_RXDATA     8'h30
`define PRX_OFS_P0R        8'h34
`define PRX_OFS_P0L        8'h38
`define PRX_OFS_P1R        8'h3c

// ==========================================================================
// Field positions.
`define PRX_HPF_LEFT_BIT   3
`define PRX_HPF_RIGHT_BIT  2
`define PRX_CUTOFF_MSB     1
`define PRX_RFT_MSB        14
`define PRX_RFT_LSB        8
`define PRX_DMA_EN_BIT     8
`define PRX_RDL_MSB        6
`define PRX_INT_OVF_BIT    1
`define PRX_INT_THR_BIT    0

// ==========================================================================
// Reset values.
`define PRX_RDL_RESET      7'h1f

// ==========================================================================
// Queue size and decimation.
`define PRX_FIFO_DEPTH     7'h40
`define PRX_DEC_LAST       6'h3f
`define PRX_DEC_MID        7'h20
`define PRX_ONES_MAX       7'h40

// ==========================================================================
// Filter corner shifts, one per cutoff code.
`define PRX_HPF_K0         4'he
`define PRX_HPF_K1         4'ha
`define PRX_HPF_K2         4'h8
`define PRX_HPF_K3         4'h7

`endif

// ===== hdl/prx_pkg.sv
package prx_pkg;

  // ========================================================================
  // Cutoff codes of the filter.
  typedef enum logic [1:0] {
    PRX_CUT_3HZ79 = 2'b00,
    PRX_CUT_60HZ  = 2'b01,
    PRX_CUT_243HZ = 2'b10,
    PRX_CUT_493HZ = 2'b11
  } prx_cutoff_t;

  // ========================================================================
  // Register port carriers.
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } prx_bus_req_t;

  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } prx_bus_rsp_t;

  // ========================================================================
  // State of one filter.
  typedef struct packed {
    logic [23:0] dc;
    logic [15:0] y;
    logic        vld;
  } prx_hpf_state_t;

  // ========================================================================
  // State of the capture block.
  typedef struct packed {
    logic [2:0]        lclk_sync;
    logic [1:0]        d_s1;
    logic [1:0]        d_s2;
    logic [5:0]        bit_cnt;
    logic [1:0][6:0]   ones_l;
    logic [1:0][6:0]   ones_r;
    logic [3:0][15:0]  raw;
    logic              raw_vld;
    logic [3:0]        hpf_ctrl;
    logic [6:0]        rft;
    logic              dma_en;
    logic [6:0]        rdl;
    logic [1:0]        int_en;
    logic              ovf;
    logic [3:0][15:0]  smp;
    logic [1:0]        pend;
    logic [1:0][31:0]  bufm;
    logic [1:0]        buf_cnt;
    logic [63:0][31:0] mem;
    logic [5:0]        wptr;
    logic [5:0]        rptr;
    logic [6:0]        count;
    logic [31:0]       rdata;
  } prx_state_t;

endpackage : prx_pkg

// ===== hdl/prx_hpf.sv
`timescale 1ns/1ns
`default_nettype none
`include "prx_defines.svh"

module prx_hpf (
  // Clock and reset.
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Sample in.
  input  wire logic                 in_vld,
  input  wire logic                 en,
  input  wire prx_pkg::prx_cutoff_t cutoff,
  input  wire logic [15:0]          x,
  // Sample out.
  output var  logic [15:0]          y,
  output var  logic                 y_vld
);
  import prx_pkg::*;

  prx_hpf_state_t   st;
  prx_hpf_state_t   nxt;
  logic [3:0]       k;
  logic signed [24:0] e;

  // ========================================================================
  // First-order DC tracker; the corner scales with the sample rate.
  // The tracker runs while bypassed so enabling gives no step.
  always_comb begin
    nxt     = st;
    nxt.vld = 1'b0;
    case (cutoff)
      PRX_CUT_3HZ79: k = `PRX_HPF_K0;
      PRX_CUT_60HZ:  k = `PRX_HPF_K1;
      PRX_CUT_243HZ: k = `PRX_HPF_K2;
      PRX_CUT_493HZ: k = `PRX_HPF_K3;
      default:       k = `PRX_HPF_K0;
    endcase
    e = 25'($signed({x, 8'h00})) - 25'($signed(st.dc));
    if (in_vld) begin
      nxt.vld = 1'b1;
      nxt.dc  = st.dc + 24'(e >>> k);
      nxt.y   = en ? e[23:8] : x;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign y     = st.y;
  assign y_vld = st.vld;

  // ========================================================================
  // Checks.
  a_hpf_bypass: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    in_vld && !en |=> y_vld && (y == $past(x)))
    else $error("Bypassed filter changed the sample.");

  a_hpf_active: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    in_vld && en && (st.dc == 24'h0) |=> y == $past(x))
    else $error("Filter with zero offset changed the sample.");

endmodule : prx_hpf
`default_nettype wire

// ===== testbench/prx_mic_model.sv
`timescale 1ns/1ns
`default_nettype none

module prx_mic_model (
  // Link pins.
  output var logic       mic_clk,
  output var logic [1:0] mic_data
);

  // ==========================================================================
  // Idle state.
  // The bit clock stands still between frames, as real microphones see it.
  initial begin
    mic_clk  = 1'b0;
    mic_data = 2'b01;
  end

  // ==========================================================================
  // Frame generator.
  // One frame is 64 periods of 160 ns: left level across the rising edge, right
  // across the falling edge, each settled 40 ns before the edge that samples it.
  task automatic send(input logic [1:0] lft, input logic [1:0] rgt);
    for (int i = 0; i < 64; i++) begin
      mic_data = lft;
      #40 mic_clk = 1'b1;
      #40 mic_data = rgt;
      #40 mic_clk = 1'b0;
      #40;
    end
    // A released line must not look like a held level.
    mic_data = ~rgt;
  endtask : send

endmodule : prx_mic_model
`default_nettype wire

// ===== testbench/test_pdm_rx_fifo_irq_dma_regs.sv
`timescale 1ns/1ns
`default_nettype none

module test_pdm_rx_fifo_irq_dma_regs;
  import prx_pkg::*;

  // ==========================================================================
  // Signals and scoreboard.
  logic         clk_sys         = 1'b0;
  logic         rst_n           = 1'b0;
  prx_bus_req_t bus_req         = '0;
  prx_bus_rsp_t bus_rsp;
  logic         mic_clk;
  logic [1:0]   mic_data;
  logic         dma_rx_req;
  logic         irq;
  int           error_cnt       = 0;
  int           samples_checked = 0;
  integer       seed            = 32'h8aaf;
  logic [32:0]  exp_q[$];
  logic [31:0]  word_q[$];
  logic [1:0]   lv;
  logic [1:0]   rv;

  always #5 clk_sys = ~clk_sys;

  prx_capture dut (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .bus_req    (bus_req),
    .bus_rsp    (bus_rsp),
    .mic_clk    (mic_clk),
    .mic_data   (mic_data),
    .dma_rx_req (dma_rx_req),
    .irq        (irq)
  );

  prx_mic_model mic (
    .mic_clk  (mic_clk),
    .mic_data (mic_data)
  );

  // ==========================================================================
  // Reporting.
  task automatic fail(input string msg);
    $display("[ERR] %0t %s", $time, msg);
    error_cnt++;
  endtask : fail

  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // ==========================================================================
  // Register bus: setup then access, held until ready is seen high.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(negedge clk_sys);
    bus_req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
    @(negedge clk_sys);
    bus_req.enable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bus_rsp.ready !== 1'b1 && n < 8);
    if (bus_rsp.ready !== 1'b1) begin
      fail("bus ready never came");
      conclude();
    end
    @(negedge clk_sys);
    bus_req <= '0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // Watches every read answer and compares it with the oldest note.
  always @(posedge clk_sys) begin : mon
    logic [32:0] e;
    if (rst_n && bus_req.sel && bus_req.enable && !bus_req.write) begin
      if (exp_q.size() == 0) begin
        fail("read answer without a note");
      end else begin
        e = exp_q.pop_front();
        samples_checked++;
        if ({bus_rsp.slverr, bus_rsp.rdata} !== e) begin
          $display("[ERR] %0t read %h got %h exp %h", $time, bus_req.addr,
                   {bus_rsp.slverr, bus_rsp.rdata}, e);
          error_cnt++;
        end
      end
    end
  end

  // ==========================================================================
  // Link traffic and expected queue words.
  function automatic logic [15:0] pcm(input logic b);
    return b ? 16'h7c00 : 16'h8000;
  endfunction : pcm

  function automatic logic [32:0] sx(input logic b);
    return {1'b0, {16{~b}}, pcm(b)};
  endfunction : sx

  // The queue plus its two-entry buffer keep 66 words; later ones are lost.
  task automatic frame;
    lv = 2'($random(seed));
    rv = 2'($random(seed));
    mic.send(lv, rv);
    for (int p = 0; p < 2; p++) begin
      if (word_q.size() < 66) word_q.push_back({pcm(rv[p]), pcm(lv[p])});
    end
    repeat (20) @(posedge clk_sys);
  endtask : frame

  task automatic drain;
    while (word_q.size() > 0) rd(8'h30, {1'b0, word_q.pop_front()});
  endtask : drain

  // ==========================================================================
  // Scenarios.
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h18, 33'h1f);
    rd(8'h10, 33'h0);
    rd(8'h1c, 33'h0);
    rd(8'h24, 33'h0);
    rd(8'h2c, 33'h1_0000_0000);
    chk(irq, 0);
    chk(dma_rx_req, 0);
    for (int k = 0; k < 16; k++) begin
      wr(8'h10, 32'hfffffff0 | k);
      rd(8'h10, {29'h0, 4'(k)});
    end
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h100);
    wr(8'h1c, 32'h1);
    frame();
    rd(8'h14, 33'h102);
    rd(8'h24, 33'h1);
    chk(irq, 1);
    rd(8'h34, sx(rv[0]));
    rd(8'h38, sx(lv[0]));
    rd(8'h3c, sx(rv[1]));
    wr(8'h18, 32'h101);
    chk(dma_rx_req, 1);
    wr(8'h18, 32'h102);
    chk(dma_rx_req, 0);
    wr(8'h18, 32'h001);
    chk(dma_rx_req, 0);
    wr(8'h1c, 32'h0);
    chk(irq, 0);
    drain();
    rd(8'h14, 33'h100);
    rd(8'h30, 33'h0);
    wr(8'h1c, 32'h2);
    repeat (34) frame();
    rd(8'h24, 33'h3);
    rd(8'h14, 33'h140);
    chk(irq, 1);
    wr(8'h1c, 32'h0);
    chk(irq, 0);
    wr(8'h1c, 32'h2);
    wr(8'h20, 32'h2);
    rd(8'h24, 33'h1);
    rd(8'h20, 33'h0);
    chk(irq, 0);
    drain();
    // Left filters on, right bypassed: right samples must pass unchanged.
    wr(8'h10, 32'hb);
    frame();
    rd(8'h34, sx(rv[0]));
    rd(8'h3c, sx(rv[1]));
    conclude();
  end

  // A hang ends the run through the same report.
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail("run timed out");
    conclude();
  end

endmodule : test_pdm_rx_fifo_irq_dma_regs
`default_nettype wire
